// ==== src/rtcb_pkg.sv ====
// Constants, register map and state type for the banked RTC register map
package rtcb_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned TIMER_BASE_HZ = 4096;
  localparam logic [11:0] TIMER_BASE_DIV = 12'(CLK_HZ / TIMER_BASE_HZ);

  // ==========================================================================
  // Addresses shared by both banks
  localparam logic [3:0] ADR_CR1 = 4'hd;
  localparam logic [3:0] ADR_CR2 = 4'he;
  localparam logic [3:0] ADR_CR3 = 4'hf;

  // Bank 0: counters sit at their own index (0x0 .. 0xc)
  localparam logic [3:0] ADR_SEC_U  = 4'h0;
  localparam logic [3:0] ADR_SEC_T  = 4'h1;
  localparam logic [3:0] ADR_MIN_U  = 4'h2;
  localparam logic [3:0] ADR_MIN_T  = 4'h3;
  localparam logic [3:0] ADR_HR_U   = 4'h4;
  localparam logic [3:0] ADR_HR_T   = 4'h5;
  localparam logic [3:0] ADR_WDAY   = 4'h6;
  localparam logic [3:0] ADR_DAY_U  = 4'h7;
  localparam logic [3:0] ADR_DAY_T  = 4'h8;
  localparam logic [3:0] ADR_MON_U  = 4'h9;
  localparam logic [3:0] ADR_MON_T  = 4'ha;
  localparam logic [3:0] ADR_YR_U   = 4'hb;
  localparam logic [3:0] ADR_YR_T   = 4'hc;

  // Bank 1
  localparam logic [3:0] ADR_PIRQ_SEL = 4'h0;
  localparam logic [3:0] ADR_ADJUST   = 4'h1;
  localparam logic [3:0] ADR_ALM_MU   = 4'h2;
  localparam logic [3:0] ADR_ALM_HT   = 4'h5;
  localparam logic [3:0] ADR_HFMT     = 4'ha;
  localparam logic [3:0] ADR_LEAP     = 4'hb;
  localparam logic [3:0] ADR_TSRC     = 4'hc;

  // ==========================================================================
  // Field positions
  localparam int CR1_CARRY_EN = 3;
  localparam int CR1_ALARM_EN = 2;
  localparam int CR1_TMR      = 1;
  localparam int CR1_BANK     = 0;
  localparam int CR2_XSTP     = 0;
  localparam int CR3_WTRST    = 1;
  localparam int ADJ_BIT      = 0;
  localparam int HFMT_BIT     = 0;
  localparam int LEAP_EN_BIT  = 2;
  localparam int TSRC_EN_BIT  = 3;

  // Writable bits of counters (index = address) and alarm registers
  localparam logic [12:0][3:0] CNT_MASK = {
    4'hf, 4'hf, 4'h1, 4'hf, 4'h3, 4'hf, 4'h7,
    4'h3, 4'hf, 4'h7, 4'hf, 4'h7, 4'hf};
  localparam logic [3:0][3:0] ALM_MASK = {4'h3, 4'hf, 4'h7, 4'hf};
  // Reset date is day 01, month 01, everything else zero
  localparam logic [12:0][3:0] CNT_RESET = {
    4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h1, 4'h0,
    4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};

  localparam logic [3:0] NIB_ZERO = 4'h0;

  // ==========================================================================
  // Complete state of the block
  typedef struct packed {
    logic [1:0]       cs_n_s;
    logic [1:0]       rd_n_s;
    logic [1:0]       wr_n_s;
    logic [1:0]       ce_s;
    logic [1:0][3:0]  addr_s;
    logic [1:0][3:0]  din_s;
    logic             wr_n_d;
    logic             wr_sel;
    logic [3:0]       wr_addr;
    logic [3:0]       wr_data;
    logic [3:0]       dout;
    logic             bank;
    logic             carry_en;
    logic             alarm_en;
    logic             carry_pend;
    logic             busy;
    logic             xstp;
    logic             alfg;
    logic [12:0][3:0] tc;
    logic [3:0][3:0]  alm;
    logic [3:0]       pirq_sel;
    logic             hour_fmt;
    logic             leap_en;
    logic [3:0]       tsrc;
    logic [23:0]      sec_div;
    logic [11:0]      base_div;
    logic [6:0]       pre;
    logic [7:0]       timer;
    logic             tmfg;
  } rtcb_state_t;

endpackage : rtcb_pkg

// ==== src/rtcb_regmap.sv ====
// Banked RTC register map with BCD time counters, alarm and timer
//
// What this block does
// - Bank bit picks counters or alarm/config registers
// - Control registers at Dh-Fh in both banks
// - Access follows read-write, read-only, write-only bits
// - Writes to read-only or blank bits ignored
// - Write-only and blank bits read as zero
// - Control register 1 reads all zero
// - Timer restart bit 1 clears timer, 0 nothing
// - Timer rate comes from timer source register
// - Alarm enable gates alarm interrupt on match
// - Clearing alarm enable releases interrupt output
// - Enable during match asserts interrupt within 61.1us
// - Carry enable gates one-second carry into seconds
// - Blocked carry remembered, applied when enabled
// - Interface enable low forces carry enable high
`timescale 1ns/1ps
`default_nettype none

module rtcb_regmap
  import rtcb_pkg::*;
#(
  parameter int unsigned SEC_DIV = CLK_HZ
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Nibble bus pins
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [3:0] addr,
  input  wire logic [3:0] data_in,
  output logic      [3:0] data_out,
  output logic            data_oe,
  // Interface enable pin
  input  wire logic       ce,
  // Open-drain interrupt pin
  output logic            irq_out_n,
  output logic            irq_out_oe
);

  // ==========================================================================
  // Helpers
  // One BCD digit step: returns {carry, digit}
  function automatic logic [4:0] step(input logic [3:0] d,
                                      input logic [3:0] lim,
                                      input logic       c);
    if (!c)
      step = {1'b0, d};
    else if (d >= lim)
      step = {1'b1, NIB_ZERO};
    else
      step = {1'b0, d + 4'h1};
  endfunction : step

  function automatic logic [1:0] year_mod4(input logic [12:0][3:0] t);
    year_mod4 = t[ADR_YR_U][1:0] + {t[ADR_YR_T][0], 1'b0};
  endfunction : year_mod4

  // Last day of the month as two BCD digits
  function automatic logic [7:0] month_end(input logic [12:0][3:0] t);
    logic [7:0] m;
    m = {t[ADR_MON_T], t[ADR_MON_U]};
    case (m)
      8'h02:   month_end = (year_mod4(t) == 2'h0) ? 8'h29 : 8'h28;
      8'h04,
      8'h06,
      8'h09,
      8'h11:   month_end = 8'h30;
      default: month_end = 8'h31;
    endcase
  endfunction : month_end

  // Ripple a carry through the calendar; from_min starts at minutes
  function automatic logic [12:0][3:0] advance(
      input logic [12:0][3:0] t, input logic from_min);
    logic [12:0][3:0] r;
    logic [4:0]       x;
    logic             c;
    r = t;
    c = 1'b1;
    if (!from_min) begin
      x = step(r[ADR_SEC_U], 4'h9, c);
      r[ADR_SEC_U] = x[3:0];
      x = step(r[ADR_SEC_T], 4'h5, x[4]);
      r[ADR_SEC_T] = x[3:0];
      c = x[4];
    end
    x = step(r[ADR_MIN_U], 4'h9, c);
    r[ADR_MIN_U] = x[3:0];
    x = step(r[ADR_MIN_T], 4'h5, x[4]);
    r[ADR_MIN_T] = x[3:0];
    c = x[4];
    if (c && r[ADR_HR_T] == 4'h2 && r[ADR_HR_U] == 4'h3) begin
      r[ADR_HR_T] = NIB_ZERO;
      r[ADR_HR_U] = NIB_ZERO;
    end else begin
      x = step(r[ADR_HR_U], 4'h9, c);
      r[ADR_HR_U] = x[3:0];
      x = step(r[ADR_HR_T], 4'h2, x[4]);
      r[ADR_HR_T] = x[3:0];
      c = 1'b0;
    end
    x = step(r[ADR_WDAY], 4'h6, c);
    r[ADR_WDAY] = x[3:0];
    if (c && {r[ADR_DAY_T], r[ADR_DAY_U]} == month_end(t)) begin
      r[ADR_DAY_T] = NIB_ZERO;
      r[ADR_DAY_U] = 4'h1;
    end else begin
      x = step(r[ADR_DAY_U], 4'h9, c);
      r[ADR_DAY_U] = x[3:0];
      x = step(r[ADR_DAY_T], 4'h3, x[4]);
      r[ADR_DAY_T] = x[3:0];
      c = 1'b0;
    end
    if (c && {r[ADR_MON_T], r[ADR_MON_U]} == 8'h12) begin
      r[ADR_MON_T] = NIB_ZERO;
      r[ADR_MON_U] = 4'h1;
    end else begin
      x = step(r[ADR_MON_U], 4'h9, c);
      r[ADR_MON_U] = x[3:0];
      x = step(r[ADR_MON_T], 4'h1, x[4]);
      r[ADR_MON_T] = x[3:0];
      c = 1'b0;
    end
    x = step(r[ADR_YR_U], 4'h9, c);
    r[ADR_YR_U] = x[3:0];
    x = step(r[ADR_YR_T], 4'h9, x[4]);
    r[ADR_YR_T] = x[3:0];
    advance = r;
  endfunction : advance

  // Alarm registers occupy bank 1 addresses 2h to 5h
  function automatic logic is_alm(input logic [3:0] a);
    is_alm = (a >= ADR_ALM_MU) && (a <= ADR_ALM_HT);
  endfunction : is_alm

  function automatic logic [1:0] alm_idx(input logic [3:0] a);
    alm_idx = 2'(a - ADR_ALM_MU);
  endfunction : alm_idx

  // Read data for one address in the current bank
  function automatic logic [3:0] read_nib(input rtcb_state_t st,
                                          input logic [3:0]  a);
    read_nib = NIB_ZERO;
    case (a)
      ADR_CR1: read_nib = NIB_ZERO;
      ADR_CR2: read_nib = {st.busy, 1'b0, st.alfg, st.xstp};
      ADR_CR3: read_nib = NIB_ZERO;
      default: begin
        if (!st.bank)
          read_nib = st.tc[a];
        else if (is_alm(a))
          read_nib = st.alm[alm_idx(a)];
        else if (a == ADR_LEAP)
          read_nib = {1'b0, st.leap_en, year_mod4(st.tc)};
        else if (a == ADR_TSRC)
          read_nib = {3'b000, st.tmfg};
        else
          read_nib = NIB_ZERO;
      end
    endcase
  endfunction : read_nib

  // ==========================================================================
  // State
  rtcb_state_t s_ff;
  rtcb_state_t nxt_s;

  logic wr_take;
  logic sec_tick;
  logic base_tick;
  logic timer_tick;
  logic alarm_match;
  logic carry_now;
  logic [6:0] tap_mask;

  always_comb begin
    nxt_s = s_ff;

    // Two-flop synchronisers; stage 0 is read only by stage 1
    nxt_s.cs_n_s = {s_ff.cs_n_s[0], cs_n};
    nxt_s.rd_n_s = {s_ff.rd_n_s[0], rd_n};
    nxt_s.wr_n_s = {s_ff.wr_n_s[0], wr_n};
    nxt_s.ce_s   = {s_ff.ce_s[0], ce};
    nxt_s.addr_s = {s_ff.addr_s[0], addr};
    nxt_s.din_s  = {s_ff.din_s[0], data_in};
    nxt_s.wr_n_d = s_ff.wr_n_s[1];

    // Address and data captured during the strobe, used at its rising edge
    if (!s_ff.wr_n_s[1]) begin
      nxt_s.wr_sel  = !s_ff.cs_n_s[1] && s_ff.ce_s[1];
      nxt_s.wr_addr = s_ff.addr_s[1];
      nxt_s.wr_data = s_ff.din_s[1];
    end
    // Commit on the rising strobe, once address and data have settled
    wr_take = s_ff.wr_n_s[1] && !s_ff.wr_n_d && s_ff.wr_sel;

    // ------------------------------------------------------------------------
    // Dividers
    // Second divider runs from reset; control register 3 restarts it
    sec_tick = (s_ff.sec_div == 24'(SEC_DIV - 1));
    nxt_s.sec_div = sec_tick ? 24'h000000 : s_ff.sec_div + 24'h000001;
    base_tick = (s_ff.base_div == TIMER_BASE_DIV - 12'h001);
    nxt_s.base_div = base_tick ? 12'h000 : s_ff.base_div + 12'h001;
    if (base_tick)
      nxt_s.pre = s_ff.pre + 7'h01;

    // Timer rate: base / 2^sel, enabled by the top bit
    tap_mask   = 7'((8'h01 << s_ff.tsrc[2:0]) - 8'h01);
    timer_tick = s_ff.tsrc[TSRC_EN_BIT] && base_tick
                 && ((s_ff.pre & tap_mask) == 7'h00);
    if (timer_tick) begin
      nxt_s.timer = s_ff.timer + 8'h01;
      if (s_ff.timer == 8'hff)
        nxt_s.tmfg = 1'b1;
    end

    // ------------------------------------------------------------------------
    // Host writes; blank and read-only bits are masked off
    nxt_s.busy = 1'b0;
    if (wr_take) begin
      case (s_ff.wr_addr)
        ADR_CR1: begin
          nxt_s.bank     = s_ff.wr_data[CR1_BANK];
          nxt_s.alarm_en = s_ff.wr_data[CR1_ALARM_EN];
          nxt_s.carry_en = s_ff.wr_data[CR1_CARRY_EN];
          if (s_ff.wr_data[CR1_TMR]) begin
            // Prescaler cleared too, so the first tick comes one full base period later, at any rate
            nxt_s.timer    = 8'h00;
            nxt_s.pre      = 7'h00;
            nxt_s.base_div = 12'h000;
            // A wrap in the restart cycle still sets the flag
            nxt_s.tmfg     = timer_tick && s_ff.timer == 8'hff;
          end
        end
        ADR_CR2: begin
          // Oscillator-stop flag can only be cleared from the bus
          if (!s_ff.wr_data[CR2_XSTP])
            nxt_s.xstp = 1'b0;
        end
        ADR_CR3: begin
          // Divider restart keeps the second aligned to this write
          if (s_ff.wr_data[CR3_WTRST]) begin
            nxt_s.sec_div = 24'h000000;
            nxt_s.busy    = 1'b1;
          end
        end
        default: begin
          if (!s_ff.bank) begin
            nxt_s.tc[s_ff.wr_addr] =
              s_ff.wr_data & CNT_MASK[s_ff.wr_addr];
          end else begin
            case (s_ff.wr_addr)
              ADR_PIRQ_SEL: nxt_s.pirq_sel = s_ff.wr_data;
              ADR_HFMT:     nxt_s.hour_fmt = s_ff.wr_data[HFMT_BIT];
              ADR_LEAP:     nxt_s.leap_en = s_ff.wr_data[LEAP_EN_BIT];
              ADR_TSRC:     nxt_s.tsrc = s_ff.wr_data;
              ADR_ADJUST: begin
                // Round to the nearest minute
                if (s_ff.wr_data[ADJ_BIT]) begin
                  nxt_s.tc = (s_ff.tc[ADR_SEC_T] >= 4'h3)
                             ? advance(s_ff.tc, 1'b1) : s_ff.tc;
                  nxt_s.tc[ADR_SEC_U] = NIB_ZERO;
                  nxt_s.tc[ADR_SEC_T] = NIB_ZERO;
                  nxt_s.busy          = 1'b1;
                end
              end
              default: begin
                if (is_alm(s_ff.wr_addr))
                  nxt_s.alm[alm_idx(s_ff.wr_addr)] =
                    s_ff.wr_data & ALM_MASK[alm_idx(s_ff.wr_addr)];
              end
            endcase
          end
        end
      endcase
    end

    // ------------------------------------------------------------------------
    // Carry into the seconds digit
    if (!s_ff.ce_s[1])
      nxt_s.carry_en = 1'b1;

    carry_now = 1'b0;
    if (sec_tick) begin
      if (s_ff.carry_en)
        carry_now = 1'b1;
      else
        nxt_s.carry_pend = 1'b1;
    end
    // A remembered carry is applied once on the enabling edge; a carry
    // arriving in that very cycle counts too, so none is left stale
    if (!s_ff.carry_en && nxt_s.carry_en && nxt_s.carry_pend) begin
      carry_now        = 1'b1;
      nxt_s.carry_pend = 1'b0;
    end
    if (carry_now) begin
      nxt_s.tc   = advance(nxt_s.tc, 1'b0);
      nxt_s.busy = 1'b1;
    end

    // ------------------------------------------------------------------------
    // Alarm: level output, follows enable and match every cycle
    alarm_match = (s_ff.alm[0] == s_ff.tc[ADR_MIN_U])
               && (s_ff.alm[1] == s_ff.tc[ADR_MIN_T])
               && (s_ff.alm[2] == s_ff.tc[ADR_HR_U])
               && (s_ff.alm[3] == s_ff.tc[ADR_HR_T]);
    nxt_s.alfg = s_ff.alarm_en && alarm_match;

    // ------------------------------------------------------------------------
    // Read data, refreshed each cycle from the synchronised address
    // Limitation: valid three clocks after the address settles
    nxt_s.dout = read_nib(s_ff, s_ff.addr_s[1]);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_ff          <= '0;
      // Interface counts as disabled until the pin has been seen
      s_ff.cs_n_s   <= 2'b11;
      s_ff.rd_n_s   <= 2'b11;
      s_ff.wr_n_s   <= 2'b11;
      s_ff.wr_n_d   <= 1'b1;
      s_ff.carry_en <= 1'b1;
      s_ff.xstp     <= 1'b1;
      s_ff.tc       <= CNT_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================================
  // Pins
  assign data_out   = s_ff.dout;
  assign data_oe    = !s_ff.cs_n_s[1] && !s_ff.rd_n_s[1] && s_ff.ce_s[1];
  assign irq_out_n  = 1'b0;
  assign irq_out_oe = s_ff.alfg;

endmodule : rtcb_regmap

`default_nettype wire

// ==== verification/rtcb_regmap_sva.sv ====
// Pin-level assertions for the banked RTC register map
`timescale 1ns/1ps
`default_nettype none

module rtcb_regmap_sva
  import rtcb_pkg::*;
(
  // Clock and reset
  input wire logic       clock,
  input wire logic       nrst,
  // Nibble bus
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic [3:0] addr,
  input wire logic [3:0] data_in,
  input wire logic [3:0] data_out,
  input wire logic       data_oe,
  // Enable and interrupt
  input wire logic       ce,
  input wire logic       irq_out_n,
  input wire logic       irq_out_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // ==========================================================================
  // Bus drive follows strobes seen through the two-flop synchroniser
  a_oe_on_read: assert property (
    (!$past(rd_n, 2) && !$past(cs_n, 2) && $past(ce, 2) &&
     !$past(rd_n) && !$past(cs_n) && $past(ce)) |-> data_oe)
    else $error("data bus not driven during read");
  a_oe_holds: assert property (
    (!rd_n && !$past(rd_n) && !cs_n && !$past(cs_n) && ce && $past(ce))
    |=> data_oe)
    else $error("data bus drive dropped during read");
  a_oe_off_rd: assert property (
    $past(rd_n, 2) |-> !data_oe)
    else $error("data bus driven without read strobe");
  a_oe_off_cs: assert property (
    $past(cs_n, 2) |-> !data_oe)
    else $error("data bus driven without chip select");
  a_oe_off_ce: assert property (
    !$past(ce, 2) |-> !data_oe)
    else $error("data bus driven with interface disabled");

  // ==========================================================================
  // Alarm disable written to control register 1 frees the pin in 4 clocks
  a_irq_release: assert property (
    ($rose(wr_n) && !cs_n && ce && $past(ce) && addr == ADR_CR1 &&
     !data_in[CR1_ALARM_EN]) |-> ##4 !irq_out_oe)
    else $error("interrupt pin held after alarm disable");

  // ==========================================================================
  // Write-only control registers read back as zero
  a_cr1_reads_zero: assert property (
    (data_oe && addr == ADR_CR1 && $past(addr) == ADR_CR1 &&
     $past(addr, 2) == ADR_CR1 && $past(addr, 3) == ADR_CR1)
    |-> data_out == NIB_ZERO)
    else $error("control register 1 read not zero");
  a_cr3_reads_zero: assert property (
    (data_oe && addr == ADR_CR3 && $past(addr) == ADR_CR3 &&
     $past(addr, 2) == ADR_CR3 && $past(addr, 3) == ADR_CR3)
    |-> data_out == NIB_ZERO)
    else $error("control register 3 read not zero");
endmodule : rtcb_regmap_sva

bind rtcb_regmap rtcb_regmap_sva u_sva (
  .clock(clock), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
  .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
  .ce(ce), .irq_out_n(irq_out_n), .irq_out_oe(irq_out_oe));

`default_nettype wire

// ==== verification/rtcb_host_model.sv ====
// Host processor model driving the nibble bus pins
`timescale 1ns/1ps
`default_nettype none

module rtcb_host_model (
  // Clock
  input  wire logic       clock,
  // Strobes and address
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [3:0] addr,
  output logic      [3:0] data_in,
  // Read return
  input  wire logic [3:0] data_out,
  input  wire logic       data_oe
);
  logic [3:0] last_v;

  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 4'h0;
    data_in = 4'h0;
    last_v = 4'h0;
  end

  // Each phase spans four cycles so the synchroniser never misses it
  task automatic wr_nib(input logic [3:0] a, input logic [3:0] d);
    @(posedge clock);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    addr <= a;
    data_in <= d;
    repeat (4) @(posedge clock);
    wr_n <= 1'b1;
    repeat (4) @(posedge clock);
    cs_n <= 1'b1;
    data_in <= ~d;
    repeat (4) @(posedge clock);
  endtask : wr_nib

  // Undriven bus shows the inverse of the last value, not a stale copy
  task automatic rd_nib(input logic [3:0] a, output logic [3:0] d);
    @(posedge clock);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    addr <= a;
    repeat (6) @(posedge clock);
    d = data_oe ? data_out : ~last_v;
    last_v = d;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (5) @(posedge clock);
  endtask : rd_nib
endmodule : rtcb_host_model

`default_nettype wire

// ==== verification/rtcb_regmap_tb.sv ====
// Self-checking bench for the banked RTC register map
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("ERROR %0t got %h want %h", $time, got, exp); \
  end \
end

module rtcb_regmap_tb
  import rtcb_pkg::*;
;
  localparam int unsigned SEC_CYC  = 2000;
  localparam int          IRQ_WAIT = 611;

  logic       clock, nrst, ce, cs_n, rd_n, wr_n, data_oe, irq_n, irq_oe;
  logic [3:0] addr, data_in, data_out;
  int         err_count = 0;
  int         num_checks = 0;
  logic       bank_m;
  logic       leap_m;
  logic [3:0] cr2_m;
  logic [3:0] m0 [13];
  logic [3:0] m1 [4];

  rtcb_regmap #(.SEC_DIV(SEC_CYC)) uut (
    .clock(clock), .nrst(nrst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .ce(ce), .irq_out_n(irq_n), .irq_out_oe(irq_oe));
  rtcb_host_model host (
    .clock(clock), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

  function automatic logic [3:0] model_rd(input logic [3:0] a);
    if (a == ADR_CR2) return cr2_m;
    if (a >= ADR_CR1) return NIB_ZERO;
    if (!bank_m) return m0[a];
    if (a >= ADR_ALM_MU && a <= ADR_ALM_HT) return m1[a - ADR_ALM_MU];
    if (a == ADR_LEAP)
      return {1'b0, leap_m, 2'((m0[ADR_YR_T] * 10 + m0[ADR_YR_U]) % 4)};
    return NIB_ZERO;
  endfunction : model_rd

  task automatic put(input logic [3:0] a, input logic [3:0] d);
    host.wr_nib(a, d);
    if (a == ADR_CR1) bank_m = d[CR1_BANK];
    else if (a < ADR_CR1 && !bank_m) m0[a] = d & CNT_MASK[a];
    else if (bank_m && a >= ADR_ALM_MU && a <= ADR_ALM_HT)
      m1[a - ADR_ALM_MU] = d & ALM_MASK[a - ADR_ALM_MU];
    else if (bank_m && a == ADR_LEAP) leap_m = d[LEAP_EN_BIT];
  endtask : put

  task automatic chk(input logic [3:0] a);
    logic [3:0] v;
    host.rd_nib(a, v);
    `CHK(v, model_rd(a))
  endtask : chk

  task automatic wait_irq(input logic lvl);
    for (int n = 0; n < IRQ_WAIT && irq_oe !== lvl; n++) @(posedge clock);
  endtask : wait_irq

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    complete_run();
  end

  initial begin
    logic [3:0] d;
    nrst = 1'b0;
    ce = 1'b1;
    bank_m = 1'b0;
    leap_m = 1'b0;
    cr2_m = 4'h1;
    for (int i = 0; i < 13; i++) m0[i] = CNT_RESET[i];
    for (int i = 0; i < 4; i++) m1[i] = 4'h0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    d = 4'($urandom(2));
    // ========================================================================
    // Reset contents of bank 0 and the shared control registers
    for (int a = 0; a < 16; a++) chk(4'(a));
    $display("test reset done");
    // Counters with carries held off so time stays put
    put(ADR_CR1, 4'h0);
    for (int a = 0; a < 13; a++) put(4'(a), 4'($urandom));
    for (int a = 0; a < 13; a++) chk(4'(a));
    $display("test bank0 done");
    // ========================================================================
    // Bank 1, read straight after the switch
    put(ADR_CR1, 4'h1);
    chk(ADR_ALM_MU);
    for (int a = 0; a < 13; a++) begin
      d = 4'($urandom);
      if (a == ADR_ADJUST) d[ADJ_BIT] = 1'b0;
      put(4'(a), d);
    end
    for (int a = 0; a < 13; a++) chk(4'(a));
    put(ADR_CR1, 4'h0);
    for (int a = 2; a < 6; a++) chk(4'(a));
    $display("test bank1 done");
    // ========================================================================
    // Alarm equal to current time, then enable and disable
    put(ADR_CR1, 4'h1);
    for (int a = 2; a < 6; a++) put(4'(a), m0[a]);
    `CHK(irq_oe, 1'b0)
    put(ADR_CR1, 4'h5);
    wait_irq(1'b1);
    `CHK(irq_oe, 1'b1)
    cr2_m = 4'h3;
    chk(ADR_CR2);
    put(ADR_CR1, 4'h1);
    wait_irq(1'b0);
    `CHK(irq_oe, 1'b0)
    cr2_m = 4'h1;
    put(ADR_ALM_MU, m0[2] ^ 4'h1);
    put(ADR_CR1, 4'h5);
    repeat (20) @(posedge clock);
    `CHK(irq_oe, 1'b0)
    put(ADR_CR1, 4'h0);
    $display("test alarm done");
    // ========================================================================
    // Blocked carry is kept and applied once on enable
    put(ADR_SEC_U, 4'h0);
    put(ADR_SEC_T, 4'h0);
    repeat (SEC_CYC + 100) @(posedge clock);
    chk(ADR_SEC_U);
    put(ADR_CR3, 4'h2);
    put(ADR_CR1, 4'h8);
    m0[0] = 4'h1;
    chk(ADR_SEC_U);
    $display("test carry done");
    // ========================================================================
    // Interface enable low forces carries on and refuses strobes
    put(ADR_CR1, 4'h0);
    put(ADR_SEC_U, 4'h0);
    put(ADR_CR3, 4'h2);
    repeat (SEC_CYC + 100) @(posedge clock);
    ce <= 1'b0;
    host.wr_nib(ADR_MIN_U, m0[2] ^ 4'h1);
    @(posedge clock);
    ce <= 1'b1;
    m0[0] = 4'h1;
    chk(ADR_SEC_U);
    chk(ADR_MIN_U);
    $display("test enable done");
    complete_run();
  end
endmodule : rtcb_regmap_tb

`default_nettype wire
